// *** rts_pkg.sv ***
// rts_pkg: shared constants and types of the ramp time selector.
// assumes a 100 MHz system clock and a classic wishbone register port.
`default_nettype none

package rts_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_TIME_US  = 10000;
  localparam int TICK_CYCLES   = TICK_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int FRAC_BITS     = 16;

  // ------------------------------------------------------------
  // terminal function codes
  // ------------------------------------------------------------
  localparam logic [7:0] CODE_SEL1  = 8'h10;
  localparam logic [7:0] CODE_SEL2  = 8'h11;
  localparam logic [7:0] CODE_FS_NO = 8'h15;
  localparam logic [7:0] CODE_FS_NC = 8'h16;
  localparam logic [7:0] CODE_OUT_FS = 8'h2c;
  localparam logic [7:0] CODE_MOTOR = 8'h33;

  // ------------------------------------------------------------
  // parameter memory layout (entry index, byte offset = 4 * index)
  // ------------------------------------------------------------
  localparam int         NUM_TIMES   = 9;
  localparam logic [3:0] IDX_FSTOP   = 4'h8;
  localparam logic [3:0] IDX_JOG_ACC = 4'h9;
  localparam logic [3:0] IDX_JOG_DEC = 4'ha;
  localparam logic [3:0] IDX_SC_AS   = 4'hb;
  localparam logic [3:0] IDX_SC_AE   = 4'hc;
  localparam logic [3:0] IDX_SC_DS   = 4'hd;
  localparam logic [3:0] IDX_SC_DE   = 4'he;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_MEM_LAST = 8'h38;
  localparam logic [7:0] OFS_UNIT     = 8'h40;
  localparam logic [7:0] OFS_SWFREQ   = 8'h44;
  localparam logic [7:0] OFS_MAXF     = 8'h48;
  localparam logic [7:0] OFS_JOGF     = 8'h4c;
  localparam logic [7:0] OFS_FCMD     = 8'h50;
  localparam logic [7:0] OFS_INCFG    = 8'h54;
  localparam logic [7:0] OFS_CTRL     = 8'h58;
  localparam logic [7:0] OFS_STATUS   = 8'h5c;
  localparam logic [7:0] OFS_FREQ     = 8'h60;

  // ------------------------------------------------------------
  // reset values and limits
  // ------------------------------------------------------------
  localparam logic [15:0] RST_RAMP_TIME = 16'h0064;
  localparam logic [15:0] RST_SCURVE    = 16'h0014;
  localparam logic        RST_UNIT      = 1'b1;
  localparam logic [15:0] RST_MAXF      = 16'h1770;
  localparam logic [15:0] TIME_MAX_RAW  = 16'hea60;
  localparam logic [15:0] SC_MAX_RAW    = 16'h03e8;
  localparam logic [15:0] BIG_RAW       = 16'h1771;
  localparam logic [23:0] UNIT_SCALE    = 24'h00000a;

  typedef enum logic [2:0] {
    ST_WAIT, ST_RD_T, ST_RD_S1, ST_RD_S2, ST_CALC, ST_DIV, ST_APPLY
  } rts_state_type;

  typedef struct packed {
    logic       accel;
    logic       unit_rej;
    logic       fs_latched;
    logic       motor2;
    logic [1:0] set_idx;
  } rts_status_type;

endpackage

`default_nettype wire

// *** rts_param_mem.sv ***
// rts_param_mem: ramp and s-curve time settings, one write and two read ports.
// assumes one clock; both read ports give data one cycle after the address.
`default_nettype none

module rts_param_mem #(
  parameter int DW    = 16,
  parameter int DEPTH = 16
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     we_i,
  input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input  wire logic [DW-1:0]            wdata_i,
  input  wire logic [$clog2(DEPTH)-1:0] a_addr_i,
  output logic      [DW-1:0]            a_rdata_o,
  input  wire logic [$clog2(DEPTH)-1:0] b_addr_i,
  output logic      [DW-1:0]            b_rdata_o
);

  logic [DW-1:0] mem [DEPTH];

  if (DW != 16 || DEPTH < 16) begin : g_chk
    $error("rts_param_mem needs DW 16 and DEPTH of at least 16");
  end

  // settings come back to their defaults on reset
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (rst_i) begin
        mem[i] <= (i < int'(rts_pkg::IDX_SC_AS)) ? rts_pkg::RST_RAMP_TIME :
                  (i <= int'(rts_pkg::IDX_SC_DE)) ? rts_pkg::RST_SCURVE : '0;
      end else if (we_i && waddr_i == i[$clog2(DEPTH)-1:0]) begin
        mem[i] <= wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    a_rdata_o <= mem[a_addr_i];
    b_rdata_o <= mem[b_addr_i];
  end

endmodule

`default_nettype wire

// *** rts_divider.sv ***
// rts_divider: serial restoring divider, one quotient bit per clock.
// assumes start is only given while idle; a zero divisor gives all ones.
`default_nettype none

module rts_divider #(
  parameter int W = 32
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         start_i,
  input  wire logic [W-1:0] num_i,
  input  wire logic [W-1:0] den_i,
  output logic      [W-1:0] quo_o,
  output logic              done_o
);

  logic [W:0]           rem;
  logic [W-1:0]         den;
  logic [$clog2(W):0]   cnt;
  logic                 busy;

  if (W < 2) begin : g_chk
    $error("rts_divider needs W of at least 2");
  end

  wire logic [W:0] shifted = {rem[W-1:0], quo_o[W-1]};
  wire logic [W:0] diff    = shifted - {1'b0, den};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rem    <= '0;
      den    <= '0;
      quo_o  <= '0;
      cnt    <= '0;
      busy   <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= busy && cnt == 1;
      if (start_i) begin
        rem   <= '0;
        den   <= den_i;
        quo_o <= num_i;
        cnt   <= ($clog2(W)+1)'(W);
        busy  <= 1'b1;
      end else if (busy) begin
        rem   <= diff[W] ? shifted : diff;
        quo_o <= {quo_o[W-2:0], ~diff[W]};
        cnt   <= cnt - 1'b1;
        busy  <= cnt != 1;
      end
    end
  end

endmodule

`default_nettype wire

// *** rts_ramp_time_selector.sv ***
// rts_ramp_time_selector: picks the active ramp times and ramps the output frequency.
// assumes terminal inputs synchronous to clk_i and a classic wishbone master.
// Function
// - no select input in use: ramp set 1 is active
// - select inputs 16 and 17 pick one of four sets by level
// - input code 51 switches motor 1 or 2; not with permanent-magnet motor
// - motor 2 uses sets 3 and 4; motor 1 can use any of the four sets
// - nonzero switch frequency, motor 1: set 4 below, set 1 at or above
// - motor 2 with frequency switching: set 4 below, set 3 above
// - select inputs override frequency switching
// - fast stop inputs 21 or 22 latch even briefly; decelerate on fast stop time
// - restart only after stop complete, fast stop input gone, run recycled
// - output code 44 is on while fast stop is in progress
// - fault reaction of fast stop also uses fast stop time
// - time unit 0 gives 0.01 s steps, 1 gives 0.1 s; default 1
// - unit 0 refused while any ramp or fast stop time set under unit 1 is 600.1 s or more
// - jog ramps between zero and jog frequency over jog times
// - four s-curve times, 0.00 to 10.00 s, default 0.20 s
// - ramp duration grows by half the sum of its two s-curve times
// - ramp time spans zero to maximum output frequency
`default_nettype none

module rts_ramp_time_selector #(
  parameter int NUM_IN      = 4,
  parameter int TICK_CYCLES = rts_pkg::TICK_CYCLES
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic              wb_we_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic [NUM_IN-1:0] mf_in_i,
  input  wire logic              run_i,
  input  wire logic              jog_i,
  input  wire logic              fault_fstop_i,
  output logic      [15:0]       freq_o,
  output logic                   mf_out_o
);

  if (NUM_IN < 1 || NUM_IN > 4 || TICK_CYCLES < 64) begin : g_chk
    $error("rts_ramp_time_selector: NUM_IN 1..4 and TICK_CYCLES >= 64");
  end

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic                  pend;
  logic                  unit;
  logic                  unit_rej;
  logic [15:0]           sw_freq;
  logic [15:0]           maxf;
  logic [15:0]           jogf;
  logic [15:0]           fcmd;
  logic [31:0]           in_cfg;
  logic [7:0]            out_cfg;
  logic                  pm_motor;
  logic [rts_pkg::NUM_TIMES-1:0] big;
  logic                  fs_latched;
  logic                  run_off_seen;
  logic [31:0]           acc;
  logic [15:0]           tgt_hold;
  logic [15:0]           ref_hold;
  logic                  dir_up;
  logic [15:0]           t_raw;
  logic [15:0]           s1;
  logic [$clog2(TICK_CYCLES)-1:0] tick_cnt;
  rts_pkg::rts_state_type state;
  rts_pkg::rts_state_type next_state;
  rts_pkg::rts_status_type status;
  logic [15:0]           a_rdata;
  logic [15:0]           b_rdata;
  logic [3:0]            b_addr;
  logic [31:0]           quo;
  logic                  div_done;
  logic [NUM_IN-1:0]     is_sel1;
  logic [NUM_IN-1:0]     on_sel1;
  logic [NUM_IN-1:0]     is_sel2;
  logic [NUM_IN-1:0]     on_sel2;
  logic [NUM_IN-1:0]     on_mot;
  logic [NUM_IN-1:0]     fs_hit;

  // ------------------------------------------------------------
  // wishbone slave: ack two edges after the request is seen
  // ------------------------------------------------------------
  wire logic start   = wb_cyc_i & wb_stb_i & ~pend & ~wb_ack_o;
  wire logic wr_go   = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & (wb_sel_i == 4'hf);
  wire logic aligned = wb_adr_i[1:0] == 2'h0;
  wire logic mem_hit = aligned & (wb_adr_i <= rts_pkg::OFS_MEM_LAST);
  wire logic [3:0] mem_idx = wb_adr_i[5:2];
  wire logic [15:0] wd = wb_dat_i[15:0];
  wire logic is_time = mem_idx < rts_pkg::IDX_SC_AS;
  // out of range settings are dropped rather than clamped
  wire logic val_ok  = is_time ? wd <= rts_pkg::TIME_MAX_RAW
                               : wd <= rts_pkg::SC_MAX_RAW;
  wire logic mem_we  = wr_go & mem_hit & val_ok & (wb_dat_i[31:16] == 16'h0000);
  wire logic wr_reg  = wr_go & aligned;
  wire logic unit_wr = wr_reg & (wb_adr_i == rts_pkg::OFS_UNIT);
  wire logic unit_bad = unit_wr & ~wb_dat_i[0] & (|big);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend     <= 1'b0;
      wb_ack_o <= 1'b0;
    end else begin
      pend     <= start;
      wb_ack_o <= pend;
    end
  end

  // long-time markers, kept per entry so the unit check needs no memory scan
  for (genvar k = 0; k < rts_pkg::NUM_TIMES; k++) begin : g_big
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        big[k] <= 1'b0;
      end else if (mem_we && mem_idx == 4'(k)) begin
        big[k] <= unit & (wd >= rts_pkg::BIG_RAW);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unit     <= rts_pkg::RST_UNIT;
      unit_rej <= 1'b0;
    end else if (unit_wr) begin
      unit     <= unit_bad ? unit : wb_dat_i[0];
      unit_rej <= unit_bad;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_freq  <= '0;
      maxf     <= rts_pkg::RST_MAXF;
      jogf     <= '0;
      fcmd     <= '0;
      in_cfg   <= '0;
      out_cfg  <= '0;
      pm_motor <= 1'b0;
    end else if (wr_reg) begin
      if (wb_adr_i == rts_pkg::OFS_SWFREQ) sw_freq <= wd;
      if (wb_adr_i == rts_pkg::OFS_MAXF) maxf <= wd;
      if (wb_adr_i == rts_pkg::OFS_JOGF) jogf <= wd;
      if (wb_adr_i == rts_pkg::OFS_FCMD) fcmd <= wd;
      if (wb_adr_i == rts_pkg::OFS_INCFG) in_cfg <= wb_dat_i;
      if (wb_adr_i == rts_pkg::OFS_CTRL) begin
        out_cfg  <= wb_dat_i[7:0];
        pm_motor <= wb_dat_i[8];
      end
    end
  end

  wire logic [31:0] rd_val =
    ~aligned                           ? 32'h0 :
    mem_hit                            ? {16'h0, a_rdata} :
    wb_adr_i == rts_pkg::OFS_UNIT      ? {31'h0, unit} :
    wb_adr_i == rts_pkg::OFS_SWFREQ    ? {16'h0, sw_freq} :
    wb_adr_i == rts_pkg::OFS_MAXF      ? {16'h0, maxf} :
    wb_adr_i == rts_pkg::OFS_JOGF      ? {16'h0, jogf} :
    wb_adr_i == rts_pkg::OFS_FCMD      ? {16'h0, fcmd} :
    wb_adr_i == rts_pkg::OFS_INCFG     ? in_cfg :
    wb_adr_i == rts_pkg::OFS_CTRL      ? {23'h0, pm_motor, out_cfg} :
    wb_adr_i == rts_pkg::OFS_STATUS    ? {26'h0, status} :
    wb_adr_i == rts_pkg::OFS_FREQ      ? {16'h0, freq_o} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (pend) begin
      wb_dat_o <= rd_val;
    end
  end

  rts_param_mem #(
    .DW    (16),
    .DEPTH (16)
  ) u_mem (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .we_i      (mem_we),
    .waddr_i   (mem_idx),
    .wdata_i   (wd),
    .a_addr_i  (mem_idx),
    .a_rdata_o (a_rdata),
    .b_addr_i  (b_addr),
    .b_rdata_o (b_rdata)
  );

  // ------------------------------------------------------------
  // terminal decode
  // ------------------------------------------------------------
  for (genvar i = 0; i < NUM_IN; i++) begin : g_in
    wire logic [7:0] code = in_cfg[8*i +: 8];
    assign is_sel1[i] = code == rts_pkg::CODE_SEL1;
    assign is_sel2[i] = code == rts_pkg::CODE_SEL2;
    assign on_sel1[i] = is_sel1[i] & mf_in_i[i];
    assign on_sel2[i] = is_sel2[i] & mf_in_i[i];
    assign on_mot[i]  = (code == rts_pkg::CODE_MOTOR) & mf_in_i[i];
    assign fs_hit[i]  = ((code == rts_pkg::CODE_FS_NO) & mf_in_i[i]) |
                        ((code == rts_pkg::CODE_FS_NC) & ~mf_in_i[i]);
  end

  // ------------------------------------------------------------
  // ramp set selection
  // ------------------------------------------------------------
  wire logic sel_cfg = (|is_sel1) | (|is_sel2);
  wire logic sel1    = |on_sel1;
  wire logic sel2    = |on_sel2;
  wire logic motor2  = (|on_mot) & ~pm_motor;
  wire logic below   = freq_o < sw_freq;
  wire logic [1:0] set_m = motor2 ? 2'h2 : 2'h0;
  wire logic [1:0] set_idx =
    sel_cfg ? (motor2 ? {1'b1, sel1} : {sel2, sel1}) :
    (sw_freq != 16'h0) ? (below ? 2'h3 : set_m) : set_m;

  // ------------------------------------------------------------
  // fast stop latch and restart interlock
  // ------------------------------------------------------------
  wire logic fs_trig = (|fs_hit) | fault_fstop_i;
  wire logic at_zero = acc == 32'h0;
  wire logic fs_clear = fs_latched & ~fs_trig & at_zero & run_off_seen & run_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fs_latched   <= 1'b0;
      run_off_seen <= 1'b0;
    end else begin
      fs_latched   <= fs_trig | (fs_latched & ~fs_clear);
      run_off_seen <= fs_latched & ~fs_trig & ~fs_clear & (run_off_seen | ~run_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mf_out_o <= 1'b0;
    end else begin
      mf_out_o <= (out_cfg == rts_pkg::CODE_OUT_FS) & fs_latched;
    end
  end

  wire logic run_ok = run_i & ~fs_latched;
  wire logic [15:0] tgt_raw = ~run_ok ? 16'h0 : jog_i ? jogf : fcmd;
  wire logic [15:0] tgt = (tgt_raw > maxf) ? maxf : tgt_raw;

  // ------------------------------------------------------------
  // ramp engine: one step per tick
  // ------------------------------------------------------------
  wire logic tick = tick_cnt == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);

  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end

  assign b_addr =
    (state == rts_pkg::ST_RD_T) ?
      (fs_latched ? rts_pkg::IDX_FSTOP :
       jog_i ? (dir_up ? rts_pkg::IDX_JOG_ACC : rts_pkg::IDX_JOG_DEC) :
       {1'b0, set_idx, ~dir_up}) :
    (state == rts_pkg::ST_RD_S1) ? (dir_up ? rts_pkg::IDX_SC_AS : rts_pkg::IDX_SC_DS) :
    (dir_up ? rts_pkg::IDX_SC_AE : rts_pkg::IDX_SC_DE);

  // unit 1 counts 0.1 s, ten ticks of 0.01 s each
  wire logic [23:0] t_ticks = unit ? 24'(t_raw) * rts_pkg::UNIT_SCALE
                                   : 24'(t_raw);
  wire logic [16:0] s_sum = {1'b0, s1} + {1'b0, b_rdata};
  wire logic [23:0] ticks = t_ticks + 24'(s_sum[16:1]);

  // s-curve shaping is approximated by a straight ramp of the stretched length
  rts_divider #(
    .W (32)
  ) u_div (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (state == rts_pkg::ST_CALC),
    .num_i   ({ref_hold, 16'h0000}),
    .den_i   ({8'h00, ticks}),
    .quo_o   (quo),
    .done_o  (div_done)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      rts_pkg::ST_WAIT:  if (tick) next_state = rts_pkg::ST_RD_T;
      rts_pkg::ST_RD_T:  next_state = rts_pkg::ST_RD_S1;
      rts_pkg::ST_RD_S1: next_state = rts_pkg::ST_RD_S2;
      rts_pkg::ST_RD_S2: next_state = rts_pkg::ST_CALC;
      rts_pkg::ST_CALC:  next_state = rts_pkg::ST_DIV;
      rts_pkg::ST_DIV:   if (div_done) next_state = rts_pkg::ST_APPLY;
      rts_pkg::ST_APPLY: next_state = rts_pkg::ST_WAIT;
      default:           next_state = rts_pkg::ST_WAIT;
    endcase
  end

  wire logic [31:0] tgt32 = {tgt_hold, 16'h0000};
  wire logic [32:0] up_sum = {1'b0, acc} + {1'b0, quo};
  wire logic [32:0] dn_lim = {1'b0, tgt32} + {1'b0, quo};
  wire logic [31:0] acc_up = (up_sum >= {1'b0, tgt32}) ? tgt32 : up_sum[31:0];
  wire logic [31:0] acc_dn = ({1'b0, acc} <= dn_lim) ? tgt32 : acc - quo;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= rts_pkg::ST_WAIT;
      acc      <= '0;
      dir_up   <= 1'b0;
      tgt_hold <= '0;
      ref_hold <= '0;
      t_raw    <= '0;
      s1       <= '0;
    end else begin
      state <= next_state;
      if (state == rts_pkg::ST_WAIT && tick) begin
        dir_up   <= tgt > freq_o;
        tgt_hold <= tgt;
        ref_hold <= jog_i ? jogf : maxf;
      end
      if (state == rts_pkg::ST_RD_S1) t_raw <= b_rdata;
      if (state == rts_pkg::ST_RD_S2) s1 <= b_rdata;
      if (state == rts_pkg::ST_APPLY) begin
        acc <= dir_up ? acc_up : acc_dn;
      end
    end
  end

  assign freq_o = acc[31:16];

  assign status = '{accel: dir_up, unit_rej: unit_rej, fs_latched: fs_latched,
                    motor2: motor2, set_idx: set_idx};

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  set_default_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (in_cfg == 32'h0 && sw_freq == 16'h0) |-> set_idx == 2'h0)
    else $error("default ramp set not chosen");

  sel_table_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (sel_cfg && !motor2) |-> set_idx == {sel2, sel1})
    else $error("select inputs picked wrong set");

  pm_motor_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    pm_motor |-> !status.motor2)
    else $error("motor switched with permanent-magnet motor");

  motor_pair_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (sel_cfg && motor2) |-> set_idx == {1'b1, sel1})
    else $error("motor 2 pair not used");

  freq_switch_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!sel_cfg && sw_freq != 16'h0) |->
      set_idx == (freq_o < sw_freq ? 2'h3 : (motor2 ? 2'h2 : 2'h0)))
    else $error("frequency level switch wrong");

  sel_prio_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (sel_cfg && $stable(mf_in_i) && $stable(in_cfg) && $stable(pm_motor))
      |-> $stable(set_idx))
    else $error("selected set moved with frequency");

  fs_latch_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    fs_trig |=> fs_latched [*2])
    else $error("fast stop not latched");

  fs_hold_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (fs_latched && (!at_zero || fs_trig || !run_off_seen)) |=> fs_latched)
    else $error("fast stop released too early");

  fs_out_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (out_cfg == rts_pkg::CODE_OUT_FS && fs_latched) |=> mf_out_o)
    else $error("fast stop output missing");

  unit_rej_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    unit_bad |=> (unit == $past(unit)) && unit_rej)
    else $error("unit change not refused");

  ramp_step_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state == rts_pkg::ST_APPLY && dir_up) |=> acc >= $past(acc))
    else $error("accelerating step went down");

  ramp_idle_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state != rts_pkg::ST_APPLY) |=> $stable(acc))
    else $error("frequency moved outside a step");

endmodule

`default_nettype wire

// *** rts_term_model.sv ***
// rts_term_model: terminal side of the ramp selector, input levels and run command.
// assumes the bench changes its controls right after a rising clock edge.
`default_nettype none

module rts_term_model (
  input  wire logic [1:0] sel_i,
  input  wire logic       motor2_i,
  input  wire logic       fs_i,
  input  wire logic       run_i,
  output logic      [3:0] mf_in_o,
  output logic            run_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // terminal levels, high = closed
  // ----------------------------------------
  // fs passes straight through at any length; the bench only pulses it high for one cycle
  assign mf_in_o = {motor2_i, fs_i, sel_i};
  assign run_o   = run_i;
endmodule

`default_nettype wire

// *** testbench.sv ***
// testbench: register and terminal sequences for the ramp time selector.
// assumes a small tick and mostly zero ramp times, so most steps are jumps.
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0;
  logic [7:0]  adr = 0;
  logic [31:0] dat = 0, q, wb_dat_o;
  logic [1:0]  sel = 0;
  logic        m2 = 0, fs = 0, run = 0, jog = 0, flt = 0, wb_ack_o, mf_out_o, run_w;
  logic [3:0]  mf_in;
  logic [15:0] freq_o;
  int          errors = 0, n_compared = 0;
  logic [7:0]  zl [9] = '{8'h00, 8'h18, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38};

  always #5 clk_i = ~clk_i;

  rts_term_model u_rts_term_model (.sel_i(sel), .motor2_i(m2), .fs_i(fs), .run_i(run),
    .mf_in_o(mf_in), .run_o(run_w));
  rts_ramp_time_selector #(.TICK_CYCLES(100)) u_rts_ramp_time_selector (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .mf_in_i(mf_in), .run_i(run_w), .jog_i(jog), .fault_fstop_i(flt), .freq_o(freq_o),
    .mf_out_o(mf_out_o));

  // ----------------------------------------
  // bus cycles and verdict
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 0; stb <= 0; we <= 0;
  endtask

  task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    xfer(0, a, 0);
    `CHK(q & m, e)
  endtask

  task automatic close_out;
    if (errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    close_out;
  end

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    chk(8'h00, 32'h64, '1);
    chk(8'h40, 32'h1, '1);
    chk(8'h2c, 32'h14, '1);
    chk(8'h5c, 32'h0, 32'h3);
    xfer(1, 8'h00, 32'd6001);
    xfer(1, 8'h40, 32'h0);
    chk(8'h40, 32'h1, '1);
    chk(8'h5c, 32'h10, 32'h10);
    foreach (zl[i]) xfer(1, zl[i], 32'h0);
    xfer(1, 8'h44, 32'd500);
    xfer(1, 8'h54, 32'h33150000);
    xfer(1, 8'h58, 32'h2c);
    chk(8'h5c, 32'h3, 32'h3);
    m2 <= 1;
    chk(8'h5c, 32'h3, 32'h3);
    m2 <= 0;
    xfer(1, 8'h50, 32'd1000);
    run <= 1;
    repeat (300) @(posedge clk_i);
    `CHK(freq_o, 16'd1000)
    chk(8'h5c, 32'h0, 32'h3);
    m2 <= 1;
    chk(8'h5c, 32'h2, 32'h3);
    m2 <= 0;
    // a brief closure must still latch; restart only after a run cycle
    for (int i = 0; i < 2; i++) begin
      if (i == 0) fs <= 1;
      else flt <= 1;
      @(posedge clk_i);
      fs <= 0; flt <= 0;
      repeat (300) @(posedge clk_i);
      `CHK(freq_o, 16'd0)
      `CHK(mf_out_o, 1'b1)
      run <= 0;
      repeat (2) @(posedge clk_i);
      run <= 1;
      repeat (300) @(posedge clk_i);
      `CHK(freq_o, 16'd1000)
      `CHK(mf_out_o, 1'b0)
    end
    xfer(1, 8'h54, 32'h33151110);
    for (int k = 0; k < 8; k++) begin
      sel <= k[1:0]; m2 <= k[2];
      chk(8'h5c, k[2] ? {30'h0, 1'b1, k[0]} : {30'h0, k[1:0]}, 32'h3);
    end
    xfer(1, 8'h58, 32'h12c);
    chk(8'h5c, 32'h0, 32'h4);
    xfer(1, 8'h4c, 32'd500);
    jog <= 1;
    repeat (300) @(posedge clk_i);
    `CHK(freq_o, 16'd500)
    // s-curves alone stretch the ramp to 40 ticks: four steps from 500 to 1000
    xfer(1, 8'h2c, 32'd40);
    xfer(1, 8'h30, 32'd40);
    jog <= 0;
    repeat (200) @(posedge clk_i);
    `CHK(freq_o < 16'd1000, 1'b1)
    repeat (400) @(posedge clk_i);
    `CHK(freq_o, 16'd1000)
    // normally closed stop input left open latches at once
    xfer(1, 8'h54, 32'h33161110);
    repeat (300) @(posedge clk_i);
    `CHK(freq_o, 16'd0)
    `CHK(mf_out_o, 1'b1)
    close_out;
  end
endmodule

`default_nettype wire
